/* File: network_master_model.sv */
module network_master_model
(
  input wire logic i_clock,
  output logic o_wr,
  output logic o_rd,
  output logic [15:0] o_addr,
  output logic [15:0] o_wdata,
  input wire logic [15:0] i_rdata,
  input wire logic i_rd_valid,
  input wire logic i_wr_ack,
  input wire logic i_wr_reject
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    o_wr = 1'h0;
    o_rd = 1'h0;
    o_addr = 16'h0000;
    o_wdata = 16'h0000;
  end
  // one word per request; address and data invert when released so nothing stale lingers
  task automatic access(input logic w, input logic [15:0] a, d,
    output logic [16:0] r);
    @(negedge i_clock);
    o_wr = w;
    o_rd = !w;
    o_addr = a;
    o_wdata = d;
    @(negedge i_clock);
    r = w ? {15'h0000, i_wr_ack, i_wr_reject} : {i_rd_valid, i_rdata};
    o_wr = 1'h0;
    o_rd = 1'h0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask
endmodule

/* File: speed_reference_param_bank.sv */
`include "speed_reference_param_bank_defs.svh"

module speed_reference_param_bank
  import speed_reference_param_bank_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_clock_en,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic [8:0] i_top_frequency,
  input wire logic [6:0] i_speed_terminals,
  output logic [15:0] o_rdata,
  output logic o_rd_valid,
  output logic o_wr_ack,
  output logic o_wr_reject,
  output logic [3:0] o_speed_stage,
  output settings_type o_settings
);

  function automatic decode_type decode(input logic [15:0] addr);
    decode_type d;
    d = '{kind: kind_none, idx: 3'h0, low: 1'h0};
    case (addr)
      `ADDR_RANGE_START_FREQ_HIGH: d = '{kind_pair, `PAIR_RANGE_START, 1'h0};
      `ADDR_RANGE_START_FREQ_LOW: d = '{kind_pair, `PAIR_RANGE_START, 1'h1};
      `ADDR_RANGE_END_FREQ_HIGH: d = '{kind_pair, `PAIR_RANGE_END, 1'h0};
      `ADDR_RANGE_END_FREQ_LOW: d = '{kind_pair, `PAIR_RANGE_END, 1'h1};
      `ADDR_RANGE_START_VOLTAGE: d.kind = kind_start_voltage;
      `ADDR_RANGE_END_VOLTAGE: d.kind = kind_end_voltage;
      `ADDR_ZERO_START_SELECT: d.kind = kind_zero_start;
      `ADDR_REFERENCE_FILTER_DEPTH: d.kind = kind_filter_depth;
      `ADDR_SEQUENCE_ENABLE: d.kind = kind_sequence;
      `ADDR_SPEED_SELECT_ENCODING: d.kind = kind_encoding;
      `ADDR_FIRST_SPEED_HIGH: d = '{kind_pair, `PAIR_FIRST_SPEED, 1'h0};
      `ADDR_FIRST_SPEED_LOW: d = '{kind_pair, `PAIR_FIRST_SPEED, 1'h1};
      `ADDR_SPEED_PRESET1_HIGH: d = '{kind_pair, `PAIR_PRESET1, 1'h0};
      `ADDR_SPEED_PRESET1_LOW: d = '{kind_pair, `PAIR_PRESET1, 1'h1};
      `ADDR_SPEED_PRESET2_HIGH: d = '{kind_pair, `PAIR_PRESET2, 1'h0};
      `ADDR_SPEED_PRESET2_LOW: d = '{kind_pair, `PAIR_PRESET2, 1'h1};
      `ADDR_SPEED_PRESET3_HIGH: d = '{kind_pair, `PAIR_PRESET3, 1'h0};
      `ADDR_SPEED_PRESET3_LOW: d = '{kind_pair, `PAIR_PRESET3, 1'h1};
      `ADDR_FIRST_SPEED_MOTOR2_HIGH: d = '{kind_pair, `PAIR_MOTOR2, 1'h0};
      `ADDR_FIRST_SPEED_MOTOR2_LOW: d = '{kind_pair, `PAIR_MOTOR2, 1'h1};
      `ADDR_FIRST_SPEED_MOTOR3_HIGH: d = '{kind_pair, `PAIR_MOTOR3, 1'h0};
      `ADDR_FIRST_SPEED_MOTOR3_LOW: d = '{kind_pair, `PAIR_MOTOR3, 1'h1};
      default: d.kind = kind_none;
    endcase
    return d;
  endfunction

  settings_type cfg;
  settings_type next_cfg;
  logic [15:0] next_rdata;
  logic next_rd_valid;
  logic next_wr_ack;
  logic next_wr_reject;
  decode_type dec;
  logic [31:0] cand;
  logic [8:0] top_clamped;
  logic [31:0] top_centi;
  logic pair_ok;

  // out-of-range top frequency is clamped so presets never see a bogus bound
  always_comb
  begin
    if (i_top_frequency < `TOP_FREQ_MIN)
    begin
      top_clamped = `TOP_FREQ_MIN;
    end
    else if (i_top_frequency > `TOP_FREQ_MAX)
    begin
      top_clamped = `TOP_FREQ_MAX;
    end
    else
    begin
      top_clamped = i_top_frequency;
    end
    top_centi = {15'h0000, 17'({8'h00, top_clamped} * `HZ_TO_CENTI_HZ)};
  end

  always_comb
  begin
    next_cfg = cfg;
    next_rdata = o_rdata;
    next_rd_valid = 1'h0;
    next_wr_ack = 1'h0;
    next_wr_reject = 1'h0;
    dec = decode(i_addr);
    cand = cfg.pair[dec.idx];
    if (dec.low)
    begin
      cand[15:0] = i_wdata;
    end
    else
    begin
      cand[31:16] = i_wdata;
    end
    // the whole pair is checked, so a high word alone can make it invalid
    if (dec.idx == `PAIR_RANGE_START || dec.idx == `PAIR_RANGE_END)
    begin
      pair_ok = (cand <= `RANGE_FREQ_MAX);
    end
    else
    begin
      pair_ok = (cand == 32'h0000_0000) ||
        (cand >= cfg.pair[`PAIR_RANGE_START] && cand <= top_centi);
    end
    if (i_wr)
    begin
      next_wr_reject = 1'h1;
      case (dec.kind)
        kind_pair:
        begin
          if (pair_ok)
          begin
            next_cfg.pair[dec.idx] = cand;
            next_wr_reject = 1'h0;
          end
        end
        kind_start_voltage:
        begin
          if (i_wdata <= {9'h000, cfg.range_end_voltage})
          begin
            next_cfg.range_start_voltage = i_wdata[6:0];
            next_wr_reject = 1'h0;
          end
        end
        kind_end_voltage:
        begin
          if (i_wdata >= {9'h000, cfg.range_start_voltage} &&
              i_wdata <= {9'h000, `VOLTAGE_MAX})
          begin
            next_cfg.range_end_voltage = i_wdata[6:0];
            next_wr_reject = 1'h0;
          end
        end
        kind_zero_start:
        begin
          if (i_wdata <= 16'h0001)
          begin
            next_cfg.zero_start_select = i_wdata[0];
            next_wr_reject = 1'h0;
          end
        end
        kind_filter_depth:
        begin
          if (i_wdata >= {11'h000, `FILTER_DEPTH_MIN} &&
              i_wdata <= {11'h000, `FILTER_DEPTH_FIXED})
          begin
            next_cfg.reference_filter_depth = i_wdata[4:0];
            next_wr_reject = 1'h0;
          end
        end
        kind_sequence:
        begin
          if (i_wdata <= 16'h0001)
          begin
            next_cfg.sequence_enable = i_wdata[0];
            next_wr_reject = 1'h0;
          end
        end
        kind_encoding:
        begin
          if (i_wdata <= 16'h0001)
          begin
            next_cfg.speed_select_encoding = i_wdata[0];
            next_wr_reject = 1'h0;
          end
        end
        default:
        begin
          next_wr_reject = 1'h1;
        end
      endcase
      next_wr_ack = ~next_wr_reject;
    end
    if (i_rd)
    begin
      next_rd_valid = 1'h1;
      case (dec.kind)
        kind_pair: next_rdata = dec.low ? cfg.pair[dec.idx][15:0] :
          cfg.pair[dec.idx][31:16];
        kind_start_voltage: next_rdata = {9'h000, cfg.range_start_voltage};
        kind_end_voltage: next_rdata = {9'h000, cfg.range_end_voltage};
        kind_zero_start: next_rdata = {15'h0000, cfg.zero_start_select};
        kind_filter_depth: next_rdata = {11'h000, cfg.reference_filter_depth};
        kind_sequence: next_rdata = {15'h0000, cfg.sequence_enable};
        kind_encoding: next_rdata = {15'h0000, cfg.speed_select_encoding};
        default: next_rdata = 16'h0000;
      endcase
    end
    // derived views are computed from next_cfg, so they change on the same edge as the written values
    next_cfg.start_freq_effective = next_cfg.zero_start_select ?
      32'h0000_0000 : next_cfg.pair[`PAIR_RANGE_START];
    next_cfg.filter_fixed =
      (next_cfg.reference_filter_depth == `FILTER_DEPTH_FIXED);
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      cfg.pair <= {8{`RESET_FREQ_PAIR}};
      cfg.start_freq_effective <= `RESET_FREQ_PAIR;
      cfg.range_start_voltage <= `RESET_START_VOLTAGE;
      cfg.range_end_voltage <= `RESET_END_VOLTAGE;
      cfg.zero_start_select <= `RESET_ZERO_START;
      cfg.reference_filter_depth <= `RESET_FILTER_DEPTH;
      cfg.filter_fixed <= 1'h0;
      cfg.sequence_enable <= `RESET_SEQUENCE_ENABLE;
      cfg.speed_select_encoding <= `RESET_SPEED_ENCODING;
      o_rdata <= 16'h0000;
      o_rd_valid <= 1'h0;
      o_wr_ack <= 1'h0;
      o_wr_reject <= 1'h0;
    end
    else if (i_clock_en)
    begin
      cfg <= next_cfg;
      o_rdata <= next_rdata;
      o_rd_valid <= next_rd_valid;
      o_wr_ack <= next_wr_ack;
      o_wr_reject <= next_wr_reject;
    end
  end

  assign o_settings = cfg;

  // terminal pins: three stages, a change is taken once stages two and three
  // agree, which also rejects single-cycle glitches
  logic [6:0] term_s1;
  logic [6:0] term_s2;
  logic [6:0] term_s3;
  logic [6:0] term_q;
  logic [6:0] next_term_q;
  logic [3:0] next_stage;

  always_comb
  begin
    next_term_q = term_q;
    if (term_s2 == term_s3)
    begin
      next_term_q = term_s3;
    end
    next_stage = 4'h0;
    if (!cfg.speed_select_encoding)
    begin
      next_stage = next_term_q[3:0];
    end
    else
    begin
      // lowest active terminal wins when several are on
      for (int i = 6; i >= 0; i--)
      begin
        if (next_term_q[i])
        begin
          next_stage = 4'(i + 1);
        end
      end
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      term_s1 <= 7'h00;
      term_s2 <= 7'h00;
      term_s3 <= 7'h00;
      term_q <= 7'h00;
      o_speed_stage <= 4'h0;
    end
    else if (i_clock_en)
    begin
      term_s1 <= i_speed_terminals;
      term_s2 <= term_s1;
      term_s3 <= term_s2;
      term_q <= next_term_q;
      o_speed_stage <= next_stage;
    end
  end

endmodule

/* File: speed_reference_param_bank_asserts.sv */
module speed_reference_param_bank_asserts
  import speed_reference_param_bank_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_clock_en,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [6:0] i_speed_terminals,
  input wire logic o_rd_valid,
  input wire logic o_wr_ack,
  input wire logic o_wr_reject,
  input wire logic [3:0] o_speed_stage,
  input wire settings_type o_settings
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  a_wr_answer: assert property (i_clock_en && i_wr |=>
    o_wr_ack != o_wr_reject) else $error("write not answered once");
  a_rd_answer: assert property (i_clock_en && i_rd |=>
    o_rd_valid) else $error("read not answered");
  a_idle_quiet: assert property (i_clock_en && !i_wr && !i_rd |=>
    !o_wr_ack && !o_wr_reject && !o_rd_valid) else $error("stray answer");
  a_voltage_order: assert property (
    o_settings.range_start_voltage <= o_settings.range_end_voltage)
    else $error("start voltage above end voltage");
  a_end_voltage_max: assert property (
    o_settings.range_end_voltage <= 7'h64) else $error("end voltage high");
  a_range_freq: assert property (o_settings.pair[0] <= 32'h00009C40 &&
    o_settings.pair[1] <= 32'h00009C40) else $error("range freq too high");
  a_zero_start: assert property ($stable(o_settings.pair[0]) &&
    $stable(o_settings.zero_start_select) |->
    o_settings.start_freq_effective == (o_settings.zero_start_select ?
    32'h00000000 : o_settings.pair[0])) else $error("start freq wrong");
  a_filter_range: assert property (o_settings.reference_filter_depth !=
    5'h00 && o_settings.filter_fixed ==
    (o_settings.reference_filter_depth == 5'h1F)) else $error("bad filter");
  a_stage_binary: assert property ((i_clock_en &&
    !o_settings.speed_select_encoding && $stable(i_speed_terminals))[*6]
    |-> o_speed_stage == i_speed_terminals[3:0]) else $error("bad stage");
endmodule

/* File: speed_reference_param_bank_defs.svh */
`ifndef SPEED_REFERENCE_PARAM_BANK_DEFS_SVH
`define SPEED_REFERENCE_PARAM_BANK_DEFS_SVH

// holding register addresses
`define ADDR_RANGE_START_FREQ_HIGH 16'h120B
`define ADDR_RANGE_START_FREQ_LOW 16'h120C
`define ADDR_RANGE_END_FREQ_HIGH 16'h120D
`define ADDR_RANGE_END_FREQ_LOW 16'h120E
`define ADDR_RANGE_START_VOLTAGE 16'h120F
`define ADDR_RANGE_END_VOLTAGE 16'h1210
`define ADDR_SPEED_PRESET1_LOW_AS_PRINTED 16'h1210
`define ADDR_ZERO_START_SELECT 16'h1211
`define ADDR_REFERENCE_FILTER_DEPTH 16'h1212
`define ADDR_SEQUENCE_ENABLE 16'h1213
`define ADDR_SPEED_SELECT_ENCODING 16'h1215
`define ADDR_FIRST_SPEED_HIGH 16'h1216
`define ADDR_FIRST_SPEED_LOW 16'h1217
`define ADDR_SPEED_PRESET1_HIGH 16'h1218
`define ADDR_SPEED_PRESET1_LOW 16'h1219
`define ADDR_SPEED_PRESET2_HIGH 16'h121A
`define ADDR_SPEED_PRESET2_LOW 16'h121B
`define ADDR_SPEED_PRESET3_HIGH 16'h121C
`define ADDR_SPEED_PRESET3_LOW 16'h121D
`define ADDR_FIRST_SPEED_MOTOR2_HIGH 16'h2216
`define ADDR_FIRST_SPEED_MOTOR2_LOW 16'h2217
`define ADDR_FIRST_SPEED_MOTOR3_HIGH 16'h3216
`define ADDR_FIRST_SPEED_MOTOR3_LOW 16'h3217

// index of each frequency pair in the pair array
`define PAIR_RANGE_START 3'h0
`define PAIR_RANGE_END 3'h1
`define PAIR_FIRST_SPEED 3'h2
`define PAIR_PRESET1 3'h3
`define PAIR_PRESET2 3'h4
`define PAIR_PRESET3 3'h5
`define PAIR_MOTOR2 3'h6
`define PAIR_MOTOR3 3'h7

// value limits and scale factor
`define RANGE_FREQ_MAX 32'h0000_9C40
`define VOLTAGE_MAX 7'h64
`define FILTER_DEPTH_MIN 5'h01
`define FILTER_DEPTH_FIXED 5'h1F
`define TOP_FREQ_MIN 9'h01E
`define TOP_FREQ_MAX 9'h190
`define HZ_TO_CENTI_HZ 17'h00064

// reset values
`define RESET_FREQ_PAIR 32'h0000_0000
`define RESET_START_VOLTAGE 7'h00
`define RESET_END_VOLTAGE 7'h64
`define RESET_ZERO_START 1'h0
`define RESET_FILTER_DEPTH 5'h08
`define RESET_SEQUENCE_ENABLE 1'h0
`define RESET_SPEED_ENCODING 1'h0

`endif

/* File: speed_reference_param_bank_pkg.sv */
package speed_reference_param_bank_pkg;

  typedef enum logic [2:0] {
    kind_none,
    kind_pair,
    kind_start_voltage,
    kind_end_voltage,
    kind_zero_start,
    kind_filter_depth,
    kind_sequence,
    kind_encoding
  } reg_kind_type;

  typedef struct packed {
    reg_kind_type kind;
    logic [2:0] idx;
    logic low;
  } decode_type;

  typedef struct packed {
    logic [7:0][31:0] pair;
    logic [31:0] start_freq_effective;
    logic [6:0] range_start_voltage;
    logic [6:0] range_end_voltage;
    logic zero_start_select;
    logic [4:0] reference_filter_depth;
    logic filter_fixed;
    logic sequence_enable;
    logic speed_select_encoding;
  } settings_type;

endpackage

/* File: speed_reference_param_bank_tb.sv */
module speed_reference_param_bank_tb
  import speed_reference_param_bank_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clock, i_rst_n, i_clock_en, wr, rd, rd_valid, wr_ack, wr_reject;
  logic [15:0] addr, wdata, rdata;
  logic [8:0] top;
  logic [6:0] term;
  logic [16:0] frozen;
  logic [3:0] stage;
  settings_type settings;
  int error_cnt = 0;
  int cmp_count = 0;
  logic [31:0] rst_tab [7] = '{32'h120F0000, 32'h12100064, 32'h12110000,
    32'h12120008, 32'h12130000, 32'h12150000, 32'h12160000};
  logic [15:0] hi [6] = '{16'h1216, 16'h1218, 16'h121A, 16'h121C,
    16'h2216, 16'h3216};
  network_master_model m (.i_clock(i_clock), .o_wr(wr), .o_rd(rd),
    .o_addr(addr), .o_wdata(wdata), .i_rdata(rdata),
    .i_rd_valid(rd_valid), .i_wr_ack(wr_ack), .i_wr_reject(wr_reject));
  speed_reference_param_bank uut (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_clock_en(i_clock_en), .i_wr(wr), .i_rd(rd), .i_addr(addr),
    .i_wdata(wdata), .i_top_frequency(top), .i_speed_terminals(term),
    .o_rdata(rdata), .o_rd_valid(rd_valid), .o_wr_ack(wr_ack),
    .o_wr_reject(wr_reject), .o_speed_stage(stage), .o_settings(settings));
  task automatic check(input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic w(input logic [15:0] a, d, input logic ok);
    logic [16:0] r;
    m.access(1'h1, a, d, r);
    check({15'h0000, r}, ok ? 32'h00000002 : 32'h00000001);
  endtask
  task automatic rdc(input logic [15:0] a, e);
    logic [16:0] r;
    m.access(1'h0, a, 16'h0000, r);
    check({15'h0000, r}, {16'h0001, e});
  endtask
  task automatic tally_and_finish;
    if (error_cnt == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    i_clock = 1'h0;
    forever #10 i_clock = ~i_clock;
  end
  initial
  begin
    repeat (20000) @(posedge i_clock);
    error_cnt++;
    tally_and_finish();
  end
  initial
  begin
    i_rst_n = 1'h0;
    i_clock_en = 1'h1;
    top = 9'h032;
    term = 7'h00;
    // count rising edges: the clock's start at time zero may look like a fall
    repeat (8) @(posedge i_clock);
    @(negedge i_clock);
    i_rst_n = 1'h1;
    foreach (rst_tab[k]) rdc(rst_tab[k][31:16], rst_tab[k][15:0]);
    w(16'h120C, 16'h9C40, 1'h1);
    w(16'h120C, 16'h9C41, 1'h0);
    w(16'h120B, 16'h0001, 1'h0);
    rdc(16'h120C, 16'h9C40);
    w(16'h120E, 16'h1388, 1'h1);
    rdc(16'h120E, 16'h1388);
    w(16'h1210, 16'h0032, 1'h1);
    w(16'h120F, 16'h0033, 1'h0);
    w(16'h120F, 16'h0032, 1'h1);
    w(16'h1210, 16'h0031, 1'h0);
    w(16'h1210, 16'h0065, 1'h0);
    w(16'h1210, 16'h0064, 1'h1);
    rdc(16'h120F, 16'h0032);
    w(16'h1211, 16'h0001, 1'h1);
    w(16'h1211, 16'h0002, 1'h0);
    check(settings.start_freq_effective, 32'h00000000);
    w(16'h1211, 16'h0000, 1'h1);
    @(negedge i_clock);
    check(settings.start_freq_effective, 32'h00009C40);
    w(16'h1212, 16'h0000, 1'h0);
    w(16'h1212, 16'h0001, 1'h1);
    w(16'h1212, 16'h001F, 1'h1);
    check(settings.filter_fixed, 32'h00000001);
    w(16'h1212, 16'h0020, 1'h0);
    w(16'h1213, 16'h0001, 1'h1);
    w(16'h1213, 16'h0002, 1'h0);
    rdc(16'h1213, 16'h0001);
    w(16'h1215, 16'h0001, 1'h1);
    for (int k = 0; k < 8; k++)
    begin
      term = (k < 7) ? 7'h01 << k : 7'h00;
      repeat (6) @(negedge i_clock);
      check(stage, (k < 7) ? k + 1 : 0);
    end
    term = 7'h14;
    repeat (6) @(negedge i_clock);
    check(stage, 32'h00000003);
    w(16'h1215, 16'h0000, 1'h1);
    term = 7'h7B;
    repeat (6) @(negedge i_clock);
    check(stage, 32'h0000000B);
    w(16'h120C, 16'h0064, 1'h1);
    foreach (hi[k])
    begin
      w(hi[k] + 16'h0001, 16'h1388, 1'h1);
      w(hi[k] + 16'h0001, 16'h1389, 1'h0);
      w(hi[k] + 16'h0001, 16'h0063, 1'h0);
      w(hi[k], 16'h0001, 1'h0);
      rdc(hi[k] + 16'h0001, 16'h1388);
      rdc(hi[k], 16'h0000);
    end
    w(16'h1217, 16'h0000, 1'h1);
    rdc(16'h2217, 16'h1388);
    top = 9'h1F4;
    w(16'h1217, 16'h9C41, 1'h0);
    w(16'h1217, 16'h9C40, 1'h1);
    top = 9'h00A;
    w(16'h1217, 16'h0BB9, 1'h0);
    w(16'h1217, 16'h0BB8, 1'h1);
    w(16'h1214, 16'h0001, 1'h0);
    w(16'h1207, 16'h0001, 1'h0);
    rdc(16'h1214, 16'h0000);
    rdc(16'h2218, 16'h0000);
    i_clock_en = 1'h0;
    m.access(1'h1, 16'h1213, 16'h0000, frozen);
    check({15'h0000, frozen}, 32'h00000000);
    i_clock_en = 1'h1;
    rdc(16'h1213, 16'h0001);
    tally_and_finish();
  end
endmodule

bind speed_reference_param_bank speed_reference_param_bank_asserts chk (
  .i_clock(i_clock), .i_rst_n(i_rst_n), .i_clock_en(i_clock_en),
  .i_wr(i_wr), .i_rd(i_rd), .i_speed_terminals(i_speed_terminals),
  .o_rd_valid(o_rd_valid), .o_wr_ack(o_wr_ack),
  .o_wr_reject(o_wr_reject), .o_speed_stage(o_speed_stage),
  .o_settings(o_settings));
